// [core/adc_result_output_port.sv]
// What this block does
// - Low serial_parallel_select uses parallel bus; high uses serial output.
// - Master parallel with select and read low drives bus continuously.
// - Byte swap low: low byte on D[7:0]; high: lanes exchanged.
// - Parallel channel select high gives channel A, low gives channel B.
// - Channel A parallel at end of conversion; serial after channel B.
// - Serial frame is 32 bits, MSB first, both channels, 32 clocks.
// - Channel select high sends A first in frame, low sends B first.
// - Internal clock source generates serial clock and a sync output.
// - Master serial clock and sync may be inverted.
// - Read mode input picks after-conversion or during-next-conversion output, master only.
// - Read-during: sync low after each channel LSB, LSB period stretched.
// - Read-after master: busy high until 32 bits out; divider slows clock.
// - External clock gated by chip select; shift only with select, read low.
// - External clock continuous or discontinuous, idling high or low.
// - Slave read-after reads 32 bits after busy falls, up to 40 MHz.
// - Daisy chain only slave read-after; chain input sampled opposite edge.
// - Slave read-during must finish before conversion ends, else error pulse.
// - Data bus and serial lines high impedance whenever chip select or read is high; busy and error flag always driven.
// - Reset empties the buffer, clears busy and holds data bus high impedance.
`timescale 1ns/1ps
module adc_result_output_port
  import result_port_pkg::*;
#(
  parameter int RES_W = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Conversion core side
  input wire logic CONV_ACTIVE,
  input wire logic CH_A_DONE,
  input wire logic [RES_W-1:0] CH_A_RESULT,
  input wire logic CH_B_DONE,
  input wire logic [RES_W-1:0] CH_B_RESULT,
  output logic CORE_READY,
  // Mode straps
  input wire logic SERIAL_PARALLEL_SELECT,
  input wire logic BYTE_LANE_SWAP,
  input wire logic CHANNEL_SELECT,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic INVERT_SCLK,
  input wire logic INVERT_SYNC,
  input wire logic [1:0] SERIAL_CLOCK_DIVIDER,
  input wire logic READ_MODE_OR_CHAIN_IN,
  // Host strobes
  input wire logic CS_N,
  input wire logic RD_N,
  // Parallel data bus
  output logic [RES_W-1:0] DATA_OUT,
  output logic [RES_W-1:0] DATA_OE_N,
  // Serial lines
  input wire logic SCLK_IN,
  output logic SCLK_OUT,
  output logic SCLK_OE_N,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE_N,
  output logic SYNC_OUT,
  output logic SYNC_OE_N,
  // Status
  output logic BUSY,
  output logic READ_OVERRUN_FLAG
);

  logic sel_n;
  logic serial_mode;
  logic master_mode;
  logic read_during;
  result_pair_s par_q;
  result_pair_s fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [RES_W-1:0] par_word;
  logic [31:0] frame_q;
  logic [5:0] bit_q;
  ser_state_e st_q;
  logic sdo_q;
  logic sync_q;
  logic busy_q;
  logic err_q;
  logic sin_q;
  logic ext_q;
  logic ext_rise;
  logic ext_fall;
  logic gen_rise;
  logic gen_fall;
  logic gen_level;
  logic shift_edge;
  logic sample_edge;
  logic last_of_ch;
  logic chain_on;
  logic conv_q;
  logic frame_done;

  // Mode decode from straps
  assign sel_n = CS_N || RD_N;
  assign serial_mode = SERIAL_PARALLEL_SELECT;
  assign master_mode = !CLOCK_SOURCE_SELECT;
  assign read_during = READ_MODE_OR_CHAIN_IN && master_mode;
  // Chain input only meaningful in slave read-after
  assign chain_on = !master_mode && !conv_q;

  // Pair FIFO decouples conversion from the serial drain
  result_fifo #(
    .WIDTH(2 * RES_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(CH_B_DONE),
    .in_ready(fifo_in_ready),
    .in_data({par_q.ch_a, CH_B_RESULT}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  // Back-pressure stalls the converter when serial frames pile up
  assign CORE_READY = fifo_in_ready;

  // Parallel holding registers; A visible at its own done
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      par_q <= '{RESULT_RST, RESULT_RST};
    end else begin
      if (CH_A_DONE) par_q.ch_a <= CH_A_RESULT;
      if (CH_B_DONE) par_q.ch_b <= CH_B_RESULT;
    end
  end

  // Conversion activity register for edge detection
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) conv_q <= 1'b0;
    else conv_q <= CONV_ACTIVE;
  end

  // Parallel word: channel choice then byte lanes
  assign par_word = lane_order(CHANNEL_SELECT ? par_q.ch_a : par_q.ch_b,
                               BYTE_LANE_SWAP);

  // Bus drive; select and read low keeps it driven, reset releases
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DATA_OUT <= '0;
      DATA_OE_N <= '1;
    end else begin
      DATA_OUT <= par_word;
      DATA_OE_N <= {RES_W{sel_n || serial_mode}};
    end
  end

  // External clock edges from the synchronous sample
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ext_q <= 1'b0;
    else ext_q <= SCLK_IN;
  end
  // Gated by select; idle level does not matter, only edges count
  assign ext_rise = !sel_n && SCLK_IN && !ext_q;
  assign ext_fall = !sel_n && !SCLK_IN && ext_q;

  // Internal clock generator with LSB stretch in read-during
  sclk_divider #(
    .HALF_MIN(SCLK_HALF_MIN)
  ) u_div (
    .clk(CLK),
    .rst(SYS_RST),
    .run(master_mode && st_q == ST_SHIFT),
    .div(read_during ? DIV_RST : SERIAL_CLOCK_DIVIDER),
    .stretch(read_during && last_of_ch),
    .rise(gen_rise),
    .fall(gen_fall),
    .level(gen_level)
  );

  // Shift on falling edge, sample chain input on the opposite edge
  assign shift_edge = master_mode ? gen_fall : ext_fall;
  assign sample_edge = master_mode ? gen_rise : ext_rise;
  assign last_of_ch = (bit_q == 6'(RES_W - 1)) ||
                      (bit_q == 6'(FRAME_BITS - 1));
  assign frame_done = shift_edge && bit_q == 6'(FRAME_BITS - 1);
  assign fifo_pop = serial_mode && st_q == ST_IDLE && fifo_out_valid &&
                    (master_mode || !sel_n);

  // Serial frame state; frame loaded only after channel B done
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      frame_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (fifo_pop) begin
            frame_q <= frame_of(fifo_out, CHANNEL_SELECT);
            bit_q <= '0;
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          st_q <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (shift_edge) begin
            frame_q <= {frame_q[30:0], sin_q};
            bit_q <= bit_q + 6'h01;
          end
          if (frame_done) st_q <= ST_DONE;
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Chain input caught on the sampling edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) sin_q <= 1'b0;
    else if (sample_edge && chain_on) sin_q <= READ_MODE_OR_CHAIN_IN;
  end

  // Data bit register; holds between frames
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) sdo_q <= 1'b0;
    else if (st_q == ST_LOAD) sdo_q <= frame_q[31];
    else if (st_q == ST_SHIFT && shift_edge) sdo_q <= frame_q[30];
  end

  // Sync high while a channel is being sent; low after its LSB in read-during, after the frame in read-after
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) sync_q <= 1'b0;
    else if (st_q == ST_LOAD) sync_q <= 1'b1;
    else if (shift_edge && last_of_ch && read_during) sync_q <= 1'b0;
    // Back high on the second channel's first rise so the host re-arms
    else if (sample_edge && bit_q == 6'(RES_W)) sync_q <= 1'b1;
    else if (frame_done) sync_q <= 1'b0;
  end

  // Busy follows conversion, stretched in master read-after
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) busy_q <= 1'b0;
    else if (CONV_ACTIVE) busy_q <= 1'b1;
    else if (serial_mode && master_mode && !read_during &&
             (st_q != ST_IDLE || fifo_out_valid)) busy_q <= 1'b1;
    else busy_q <= 1'b0;
  end

  // Overrun pulse when a slave read-during frame is cut by conversion end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) err_q <= 1'b0;
    else err_q <= serial_mode && !master_mode && conv_q && !CONV_ACTIVE &&
                  st_q == ST_SHIFT && bit_q != '0;
  end

  // Pin drive; serial lines released unless selected and reading, busy and error flag always driven
  always_comb begin
    SERIAL_DATA_OUT = sdo_q;
    SERIAL_DATA_OE_N = sel_n || !serial_mode;
    SCLK_OUT = gen_level ^ INVERT_SCLK;
    SCLK_OE_N = sel_n || !serial_mode || !master_mode;
    SYNC_OUT = sync_q ^ INVERT_SYNC;
    SYNC_OE_N = sel_n || !serial_mode || !master_mode;
    BUSY = busy_q;
    READ_OVERRUN_FLAG = err_q;
  end

endmodule // adc_result_output_port

// [core/result_fifo.sv]
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full compares the count at its full width; AW bits would wrap to zero
  assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // Storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // result_fifo

// [core/result_port_pkg.sv]
package result_port_pkg;

  // Result and frame widths
  localparam int RESULT_W = 16;
  localparam int FRAME_BITS = 32;
  localparam int FIFO_DEPTH = 16;

  // Byte lane positions on the parallel bus
  localparam int LOW_LANE_LSB = 0;
  localparam int HIGH_LANE_LSB = 8;
  localparam int LANE_W = 8;

  // Clock figures
  localparam int CLK_MHZ = 200;
  localparam int SCLK_MAX_MHZ = 40;
  // Least internal half period so a generated clock never tops 40 MHz
  localparam int SCLK_HALF_MIN =
    (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  // Extra half periods given to each channel's last bit
  localparam int LSB_STRETCH = 2;

  // Reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [1:0] DIV_RST = 2'h0;

  // One conversion result pair, channel A and channel B
  typedef struct packed {
    logic [RESULT_W-1:0] ch_a;
    logic [RESULT_W-1:0] ch_b;
  } result_pair_s;

  // Pin group of the parallel bus, data and enables
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic [RESULT_W-1:0] oe_n;
  } bus_drive_s;

  // Serial transmit states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DONE = 4'b1000
  } ser_state_e;

  // Swap byte lanes when asked
  function automatic logic [15:0] lane_order(input logic [15:0] v,
                                             input logic swap);
    lane_order = swap ? {v[LOW_LANE_LSB +: LANE_W],
                         v[HIGH_LANE_LSB +: LANE_W]} : v;
  endfunction

  // Place the chosen channel first in a 32-bit frame
  function automatic logic [31:0] frame_of(input result_pair_s r,
                                           input logic a_first);
    frame_of = a_first ? {r.ch_a, r.ch_b} : {r.ch_b, r.ch_a};
  endfunction

endpackage

// [core/sclk_divider.sv]
`timescale 1ns/1ps
module sclk_divider #(
  parameter int HALF_MIN = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [1:0] div,
  input wire logic stretch,
  // Edge strobes of the generated clock
  output logic rise,
  output logic fall,
  output logic level
);
  logic [7:0] cnt_q;
  logic [7:0] half;
  logic lvl_q;

  // Divider code doubles the half period per step; stretch lengthens LSB
  always_comb begin
    half = 8'(HALF_MIN) << div;
    if (stretch) half = half + 8'(HALF_MIN * 2);
  end

  assign rise = run && (cnt_q == half - 8'h01) && !lvl_q;
  assign fall = run && (cnt_q == half - 8'h01) && lvl_q;
  assign level = lvl_q;

  // Half period counter and clock level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (cnt_q == half - 8'h01) begin
      cnt_q <= 8'h00;
      lvl_q <= ~lvl_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // sclk_divider

// [test/adc_result_output_port_assertions.sv]
`timescale 1ns/1ps
module port_checker #(
  parameter int RES_W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Straps and strobes
  input wire logic SERIAL_PARALLEL_SELECT,
  input wire logic BYTE_LANE_SWAP,
  input wire logic CHANNEL_SELECT,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic CONV_ACTIVE,
  input wire logic CH_A_DONE,
  input wire logic CH_B_DONE,
  input wire logic CS_N,
  input wire logic RD_N,
  // Outputs watched
  input wire logic [RES_W-1:0] DATA_OUT,
  input wire logic [RES_W-1:0] DATA_OE_N,
  input wire logic SCLK_OE_N,
  input wire logic SERIAL_DATA_OE_N,
  input wire logic SYNC_OE_N,
  input wire logic BUSY,
  input wire logic READ_OVERRUN_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic deselect, par_rd, conv_q, conv_fell;
  // Strobe decode shared by several checks
  assign deselect = CS_N || RD_N;
  assign par_rd = !deselect && !SERIAL_PARALLEL_SELECT;
  assign conv_fell = conv_q && !CONV_ACTIVE;
  // Last conversion level, to spot its falling edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) conv_q <= 1'b0;
    else conv_q <= CONV_ACTIVE;
  end
  // Bus read with no new result arriving
  sequence quiet_par;
    par_rd && !CH_A_DONE && !CH_B_DONE;
  endsequence
  sequence swap_flip;
    $changed(BYTE_LANE_SWAP) && $stable(CHANNEL_SELECT);
  endsequence
  a_bus_float: assert property (deselect |=> &DATA_OE_N)
    else $error("parallel bus driven while deselected");
  a_line_float: assert property (deselect [*2] |-> SERIAL_DATA_OE_N && SYNC_OE_N)
    else $error("serial lines driven while deselected");
  a_par_drive: assert property (par_rd [*2] |-> DATA_OE_N == '0)
    else $error("parallel bus not driven during read");
  a_par_quiet_serial: assert property ((!SERIAL_PARALLEL_SELECT) [*2] |-> SERIAL_DATA_OE_N)
    else $error("serial output driven in parallel mode");
  a_lane_swap: assert property (quiet_par [*2] ##1 (quiet_par and swap_flip)
    |=> DATA_OUT == {$past(DATA_OUT[7:0]), $past(DATA_OUT[15:8])})
    else $error("byte lanes not exchanged");
  a_ext_clock_in: assert property (CLOCK_SOURCE_SELECT [*2] |-> SCLK_OE_N)
    else $error("serial clock driven in external mode");
  a_reset_float: assert property (disable iff (1'b0)
    SYS_RST |-> &DATA_OE_N && !BUSY)
    else $error("bus or busy active in reset");
  a_overrun_once: assert property (READ_OVERRUN_FLAG |=> !READ_OVERRUN_FLAG)
    else $error("read error longer than one cycle");
  a_overrun_cause: assert property (READ_OVERRUN_FLAG
    |-> $past(conv_fell) || $past(conv_fell, 2))
    else $error("read error without conversion end");
endmodule // port_checker

bind adc_result_output_port port_checker #(.RES_W(RES_W)) chk (.*);

// [test/adc_result_output_port_tb.sv]
`timescale 1ns/1ps
module adc_result_output_port_tb;
  import result_port_pkg::*;
  logic CLK, SYS_RST, CONV_ACTIVE, CH_A_DONE, CH_B_DONE, CORE_READY;
  logic SERIAL_PARALLEL_SELECT, BYTE_LANE_SWAP, CHANNEL_SELECT;
  logic CLOCK_SOURCE_SELECT, INVERT_SCLK, INVERT_SYNC, READ_MODE_OR_CHAIN_IN;
  logic CS_N, RD_N, SCLK_IN, SCLK_OUT, SCLK_OE_N, SERIAL_DATA_OUT;
  logic SERIAL_DATA_OE_N, SYNC_OUT, SYNC_OE_N, BUSY, READ_OVERRUN_FLAG;
  logic [1:0] SERIAL_CLOCK_DIVIDER;
  logic [15:0] CH_A_RESULT, CH_B_RESULT, DATA_OUT, DATA_OE_N;
  int n_mismatch, compares;

  adc_result_output_port uut (.*);
  serial_host host (.clk(CLK), .sdo(SERIAL_DATA_OUT),
    .oe_n(SERIAL_DATA_OE_N), .sclk(SCLK_IN));

  // 200 MHz system clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Three cycles of reset; bus must float meanwhile
  task automatic do_reset();
    SYS_RST <= 1'b1;
    repeat (3) @(negedge CLK);
    check(32'(DATA_OE_N), 32'hffff);
    check(32'(BUSY), 32'h0);
    SYS_RST <= 1'b0;
    @(negedge CLK);
  endtask

  // Channel A then B; the pair enters the buffer on B
  task automatic push(input logic [15:0] a, input logic [15:0] b);
    CH_A_RESULT <= a;
    CH_A_DONE <= 1'b1;
    @(negedge CLK);
    CH_A_DONE <= 1'b0;
    CH_B_RESULT <= b;
    CH_B_DONE <= 1'b1;
    @(negedge CLK);
    CH_B_DONE <= 1'b0;
  endtask

  // Every lane and channel choice, then an early channel A
  task automatic t_parallel();
    logic [15:0] v;
    push(16'h12c4, 16'hab3d);
    CS_N <= 1'b0;
    RD_N <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      CHANNEL_SELECT <= k[1];
      BYTE_LANE_SWAP <= k[0];
      repeat (4) @(negedge CLK);
      v = k[1] ? 16'h12c4 : 16'hab3d;
      check(32'(DATA_OUT), 32'(k[0] ? {v[7:0], v[15:8]} : v));
      check(32'(DATA_OE_N), 32'h0);
    end
    CH_A_RESULT <= 16'h5e71;
    CH_A_DONE <= 1'b1;
    @(negedge CLK);
    CH_A_DONE <= 1'b0;
    repeat (2) @(negedge CLK);
    check(32'(DATA_OUT), 32'h715e);
    RD_N <= 1'b1;
    repeat (2) @(negedge CLK);
    check(32'(DATA_OE_N), 32'hffff);
  endtask

  // Fill the buffer until refused, then drain it frame by frame
  task automatic t_serial();
    logic [31:0] w;
    int n;
    do_reset();
    SERIAL_PARALLEL_SELECT <= 1'b1;
    CLOCK_SOURCE_SELECT <= 1'b1;
    CHANNEL_SELECT <= 1'b1;
    n = 0;
    @(negedge CLK);
    while (CORE_READY === 1'b1 && n < 20) begin
      push(16'h8100 + 16'(n), 16'h0a00 + 16'(n));
      n++;
    end
    check(32'(CORE_READY), 32'h0);
    CS_N <= 1'b0;
    RD_N <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge CLK);
      host.read_bits(32, i[0], w);
      check(w, {16'h8100 + 16'(i), 16'h0a00 + 16'(i)});
    end
    check(32'(CORE_READY), 32'h1);
    CHANNEL_SELECT <= 1'b0;
    @(negedge CLK);
    push(16'h6a95, 16'hc33c);
    repeat (4) @(negedge CLK);
    host.read_bits(32, 1'b1, w);
    check(w, 32'hc33c6a95);
  endtask

  // Conversion ends after eight bits of a frame are read
  task automatic t_overrun();
    logic [31:0] w;
    logic seen;
    seen = 1'b0;
    CONV_ACTIVE <= 1'b1;
    push(16'h0f0f, 16'hf0f0);
    repeat (4) @(negedge CLK);
    host.read_bits(8, 1'b1, w);
    check(w, 32'hf0);
    CONV_ACTIVE <= 1'b0;
    repeat (4) begin
      @(negedge CLK);
      seen = seen | (READ_OVERRUN_FLAG === 1'b1);
    end
    check(32'(seen), 32'h1);
  endtask

  // Watch one generated frame; a bit is taken on each true clock rise
  task automatic grab(input logic inv_c, input logic inv_s,
                      output logic [31:0] w, output int nb,
                      output int gap0, output int gap15, output int lo,
                      output logic ok);
    logic prev, now_c;
    int tr [32];
    w = '0;
    nb = 0;
    lo = 0;
    ok = 1'b1;
    prev = 1'b0;
    for (int t = 0; t < 2000 && nb < 32; t++) begin
      @(negedge CLK);
      now_c = SCLK_OUT ^ inv_c;
      if (nb > 0 && (SYNC_OUT ^ inv_s) !== 1'b1) lo++;
      if (now_c === 1'b1 && prev === 1'b0) begin
        w = {w[30:0], SERIAL_DATA_OUT};
        tr[nb] = t;
        ok = ok && (SYNC_OUT ^ inv_s) === 1'b1 && SCLK_OE_N === 1'b0 &&
             SYNC_OE_N === 1'b0 && SERIAL_DATA_OE_N === 1'b0 &&
             BUSY === !READ_MODE_OR_CHAIN_IN;
        nb++;
      end
      prev = now_c;
    end
    gap0 = tr[1] - tr[0];
    gap15 = tr[16] - tr[15];
  endtask

  // Generated clock: read-after with divider, then read-during inverted
  task automatic t_master();
    logic [31:0] w;
    int nb, gap0, gap15, lo;
    logic ok;
    do_reset();
    CLOCK_SOURCE_SELECT <= 1'b0;
    CHANNEL_SELECT <= 1'b1;
    SERIAL_CLOCK_DIVIDER <= 2'h1;
    @(negedge CLK);
    push(16'h3c5a, 16'h9617);
    grab(1'b0, 1'b0, w, nb, gap0, gap15, lo, ok);
    check(w, 32'h3c5a9617);
    check(32'(nb), 32'd32);
    check(32'(gap0), 32'(4 * SCLK_HALF_MIN));
    check(32'(lo), 32'h0);
    check(32'(ok), 32'h1);
    repeat (16) @(negedge CLK);
    check(32'(BUSY), 32'h0);
    check(32'(SYNC_OUT), 32'h0);
    READ_MODE_OR_CHAIN_IN <= 1'b1;
    INVERT_SCLK <= 1'b1;
    INVERT_SYNC <= 1'b1;
    CHANNEL_SELECT <= 1'b0;
    @(negedge CLK);
    push(16'h1248, 16'hedb7);
    grab(1'b1, 1'b1, w, nb, gap0, gap15, lo, ok);
    check(w, 32'hedb71248);
    check(32'(nb), 32'd32);
    check(32'(gap0), 32'(2 * SCLK_HALF_MIN));
    check(32'(gap15 > gap0), 32'h1);
    check(32'(lo != 0), 32'h1);
    check(32'(ok), 32'h1);
  endtask

  // Inputs settle at time zero, then the sequence runs
  initial begin
    n_mismatch = 0;
    compares = 0;
    SYS_RST = 1'b0;
    {CONV_ACTIVE, CH_A_DONE, CH_B_DONE} = 3'h0;
    {SERIAL_PARALLEL_SELECT, BYTE_LANE_SWAP, CHANNEL_SELECT} = 3'h0;
    {CLOCK_SOURCE_SELECT, INVERT_SCLK, INVERT_SYNC} = 3'h0;
    READ_MODE_OR_CHAIN_IN = 1'b0;
    SERIAL_CLOCK_DIVIDER = 2'h0;
    {CS_N, RD_N} = 2'h3;
    CH_A_RESULT = 16'h0000;
    CH_B_RESULT = 16'h0000;
    do_reset();
    t_parallel();
    t_serial();
    t_overrun();
    t_master();
    conclude();
  end
endmodule // adc_result_output_port_tb

// [test/serial_host.sv]
`timescale 1ns/1ps
module serial_host (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic sdo,
  input wire logic oe_n,
  output logic sclk
);
  // Six cycles a bit gives about 33 MHz, under the ceiling
  localparam int HALF = 3;
  initial sclk = 1'b1;
  // Bit taken before the fall that shifts the next one out;
  // a released line reads as the inverse of the last bit
  task automatic read_bits(input int n, input logic idle,
                           output logic [31:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (HALF) @(negedge clk);
      w = {w[30:0], oe_n ? ~w[0] : sdo};
      sclk <= 1'b0;
      repeat (HALF) @(negedge clk);
    end
    sclk <= idle;
  endtask
endmodule // serial_host
